// ==== verilog/stepper_fault_diagnostics.sv ====
// fault monitoring, diagnostic registers and step sequencing of the driver
//
// The register offsets and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module stepper_fault_diagnostics (
    input  wire logic                        clock,          // core clock
    input  wire logic                        nrst,           // logic supply reset
    input  wire logic                        hsel,           // ahb select
    input  wire logic [7:0]                  haddr,          // ahb address
    input  wire logic [1:0]                  htrans,         // ahb transfer type
    input  wire logic                        hwrite,         // ahb write
    input  wire logic [2:0]                  hsize,          // ahb size
    input  wire logic                        hready,         // ahb ready in
    input  wire logic [31:0]                 hwdata,         // ahb write data
    output logic      [31:0]                 hrdata,         // ahb read data
    output logic                             hreadyout,      // ahb ready out
    output logic                             hresp,          // ahb response
    input  wire logic                        stepPin,        // step input pin
    input  wire logic                        dirPin,         // direction input pin
    input  wire logic                        resetPinN,      // fault reset pin
    input  wire logic                        serialSelectN,  // serial select pin
    input  wire stepper_status_output_pin_pkg::monitor_s  monitors,       // analog comparators
    input  wire stepper_status_output_pin_pkg::pwm_s      pwmState,       // internal pwm state
    output logic                             statusOutputPin,// status pin
    output logic                             tempRouteSel,   // analog temp to pin
    output logic                             serialDataOut,  // serial out bit
    output logic                             lowThreshSel,   // regulator threshold low
    output stepper_status_output_pin_pkg::phase_drive_s   phaseA,         // phase A drive
    output stepper_status_output_pin_pkg::phase_drive_s   phaseB          // phase B drive
);
    import stepper_status_output_pin_pkg::*;

    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    monitor_s   monMeta_r;
    monitor_s   mon;
    logic [3:0] pinMeta_r;
    logic [3:0] pinSync_r;
    logic       stepOld_r;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            monMeta_r <= '0;
            mon       <= '0;
            pinMeta_r <= 4'h3;
            pinSync_r <= 4'h3;
            stepOld_r <= 1'b0;
        end else begin
            monMeta_r <= monitors;
            mon       <= monMeta_r;
            pinMeta_r <= {stepPin, dirPin, resetPinN, serialSelectN};
            pinSync_r <= pinMeta_r;
            stepOld_r <= pinSync_r[3];
        end
    end

    logic stepEdge;
    logic dirS;
    logic resetLow;
    logic selLow;
    assign stepEdge = pinSync_r[3] & ~stepOld_r;
    assign dirS     = pinSync_r[2];
    assign resetLow = ~pinSync_r[1];
    assign selLow   = ~pinSync_r[0];

    // ------------------------------------------------------------------
    // ahb-lite slave
    // ------------------------------------------------------------------
    logic       wrPend_r;
    logic [7:0] wrAddr_r;
    logic       addrPhase;
    logic       wrStrobe;
    logic [3:0] config_r;
    logic [14:0] diag0_r;
    logic [14:0] diag1_r;
    logic       commonFlag;
    logic [5:0] index_r;
    logic       dirFwd_r;
    logic [1:0] shortOff_r;
    logic [1:0] bridgeEn_r;
    logic [31:0] readMux;

    assign addrPhase = hsel & htrans[1] & hready;
    assign wrStrobe  = wrPend_r;
    assign commonFlag = |diag0_r | |diag1_r;

    always_comb begin
        readMux = 32'h0000_0000;
        unique case (haddr)
            CONFIG_OFS: readMux[3:0] = config_r;
            DIAG0_OFS:  readMux[15:0] = {commonFlag, diag0_r};
            DIAG1_OFS:  readMux[15:0] = {commonFlag, diag1_r};
            STATUS_OFS: begin
                readMux[STS_INDEX_LSB +: 6]  = index_r;
                readMux[STS_ENABLE_LSB +: 2] = bridgeEn_r;
                readMux[STS_DECAY_LSB]       = phaseA.decayMixed;
                readMux[STS_DECAY_LSB + 1]   = phaseB.decayMixed;
                readMux[STS_DIR_LSB]         = dirFwd_r;
            end
            default:    readMux = 32'h0000_0000;
        endcase
    end

    // zero wait states: read data is captured in the address phase
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wrPend_r  <= 1'b0;
            wrAddr_r  <= 8'h00;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            wrPend_r <= addrPhase & hwrite;
            if (addrPhase) begin
                wrAddr_r <= haddr;
            end
            if (addrPhase & ~hwrite) begin
                hrdata <= readMux;
            end
        end
    end

    logic serialStep;
    logic diagWrite;
    assign serialStep = wrStrobe & (wrAddr_r == STEP_CHANGE_OFS);
    assign diagWrite  = wrStrobe & ((wrAddr_r == DIAG0_OFS) | (wrAddr_r == DIAG1_OFS));

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            config_r <= CONFIG_RESET;
        end else if (wrStrobe & (wrAddr_r == CONFIG_OFS)) begin
            config_r <= hwdata[3:0];
        end
    end

    // ------------------------------------------------------------------
    // step sequencer
    // ------------------------------------------------------------------
    logic [5:0] stepSize;
    logic [5:0] delta;
    always_comb begin
        unique case (config_r[CFG_STEP_MODE_LSB +: 2])
            2'b00: stepSize = 6'h10;
            2'b01: stepSize = 6'h08;
            2'b10: stepSize = 6'h04;
            2'b11: stepSize = 6'h01;
        endcase
        if (serialStep) begin
            delta = hwdata[5:0];
        end else begin
            delta = dirS ? stepSize : 6'(-stepSize);
        end
    end

    // the 6-bit add wraps by itself; no saturation at the table ends
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            index_r  <= HOME_INDEX;
            dirFwd_r <= 1'b1;
        end else if (serialStep | stepEdge) begin
            index_r  <= index_r + delta;
            dirFwd_r <= ~delta[5];
        end
    end

    // sinusoid approximated by straight quarter segments
    function automatic logic [6:0] lookup(input logic [5:0] idx);
        logic [5:0] mag;
        mag = idx[4] ? 6'(6'h3F - {idx[3:0], 2'b00}) : {idx[3:0], 2'b00};
        return {mag, ~idx[5]};
    endfunction

    logic [5:0] indexB;
    logic [6:0] entA;
    logic [6:0] entB;
    assign indexB = index_r + 6'h10;
    assign entA   = lookup(index_r);
    assign entB   = lookup(indexB);

    // ------------------------------------------------------------------
    // short detection and output enables
    // ------------------------------------------------------------------
    logic [7:0] ocCnt_r [2];
    logic [1:0] confirm;
    logic [3:0] shortSet;
    logic       faultReset;
    assign faultReset = stepEdge | resetLow | diagWrite;

    for (genvar p = 0; p < 2; p++) begin : g_bridge
        always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
                ocCnt_r[p] <= 8'h00;
            end else if (!mon.lowOc[p]) begin
                ocCnt_r[p] <= 8'h00;
            end else if (ocCnt_r[p] != OC_CONFIRM_CYC) begin
                ocCnt_r[p] <= ocCnt_r[p] + 8'h01;
            end
        end
        assign confirm[p] = mon.lowOc[p] & (ocCnt_r[p] == 8'(OC_CONFIRM_CYC - 8'h01));
        assign shortSet[2*p]     = confirm[p] & ~pwmState.lowLeg[p];
        assign shortSet[2*p + 1] = confirm[p] & pwmState.lowLeg[p];

        always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
                shortOff_r[p] <= 1'b0;
            end else begin
                shortOff_r[p] <= confirm[p] | (shortOff_r[p] & ~faultReset);
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            bridgeEn_r <= 2'b00;
        end else begin
            bridgeEn_r <= ~shortOff_r & {2{~mon.regUv & ~mon.overTemp}};
        end
    end

    // ------------------------------------------------------------------
    // diagnostic registers
    // ------------------------------------------------------------------
    logic supplyLow;
    logic diagClear;
    logic [14:0] set0;
    logic [14:0] set1;
    assign supplyLow = mon.regUv | mon.motorUv;
    assign diagClear = diagWrite | resetLow;

    always_comb begin
        set0 = '0;
        set1 = '0;
        set0[DG_SUPPLY_LOW] = supplyLow;
        set0[DG_HOT]        = mon.hotWarn;
        set0[DG_COLD]       = mon.coldWarn;
        set0[DG_TSD]        = mon.overTemp;
        set0[DG0_SHORT_LSB +: 4] = shortSet;
        set1[DG_SUPPLY_LOW] = supplyLow;
        set1[DG_HOT]        = mon.hotWarn;
        set1[DG_COLD]       = mon.coldWarn;
        set1[DG_TSD]        = mon.overTemp;
        set1[DG1_STALL]     = mon.stall;
    end

    // a new event wins over a clear in the same cycle
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            diag0_r <= STATUS_OUTPUT_PIN_RESET;
            diag1_r <= STATUS_OUTPUT_PIN_RESET;
        end else begin
            diag0_r <= set0 | (diag0_r & ~{15{diagClear}});
            diag1_r <= set1 | (diag1_r & ~{15{diagClear}});
        end
    end

    // ------------------------------------------------------------------
    // pins and drive outputs
    // ------------------------------------------------------------------
    logic faultLive;
    assign faultLive = supplyLow | mon.hotWarn | mon.coldWarn | mon.overTemp
                     | (|shortOff_r);

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            statusOutputPin <= 1'b1;
            tempRouteSel    <= 1'b0;
            serialDataOut   <= 1'b0;
            lowThreshSel    <= 1'b0;
            phaseA          <= '0;
            phaseB          <= '0;
        end else begin
            unique case (pin_sel_e'(config_r[CFG_PIN_SEL_LSB +: 2]))
                PIN_FAULT: statusOutputPin <= ~faultLive;
                PIN_STALL: statusOutputPin <= ~mon.stall;
                PIN_PWM:   statusOutputPin <= pwmState.pwmOnA;
                PIN_TEMP:  statusOutputPin <= 1'b1;
            endcase
            tempRouteSel  <= (config_r[CFG_PIN_SEL_LSB +: 2] == PIN_TEMP);
            serialDataOut <= selLow & commonFlag;
            lowThreshSel  <= mon.motorUv;
            // mixed decay in the quadrants where the magnitude falls for this direction
            phaseA <= '{entA[6:1], entA[0], index_r[4] ~^ dirFwd_r, bridgeEn_r[0]};
            phaseB <= '{entB[6:1], entB[0], indexB[4] ~^ dirFwd_r, bridgeEn_r[1]};
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence ocNearDone(int p);
        mon.lowOc[p] && ocCnt_r[p] == 8'(OC_CONFIRM_CYC - 8'h01);
    endsequence

    step_wrap_a: assert property (serialStep |=> index_r == 6'($past(index_r) + $past(hwdata[5:0])))
        else $error("serial step change not added to index");
    phase_index_a: assert property (nrst |=> phaseA.level == $past(entA[6:1]))
        else $error("phase A level does not follow the table");
    short_confirm_a: assert property ($rose(shortOff_r[0]) |-> $past(mon.lowOc[0], 1)
                                      && $past(ocCnt_r[0]) == 8'(OC_CONFIRM_CYC - 8'h01))
        else $error("short latched without full overcurrent delay");
    oc_restart_a: assert property (!mon.lowOc[0] |=> ocCnt_r[0] == 8'h00)
        else $error("overcurrent timer did not restart");
    short_latch_a: assert property (ocNearDone(0) ##1 !faultReset |=> !bridgeEn_r[0]
                                    && (diag0_r[DG0_SHORT_LSB + 0] | diag0_r[DG0_SHORT_LSB + 1]))
        else $error("short did not disable phase A");
    rearm_a: assert property (shortOff_r[0] && faultReset && !confirm[0] |=> !shortOff_r[0])
        else $error("short not released by fault reset");
    reg_uv_off_a: assert property (mon.regUv |=> bridgeEn_r == 2'b00)
        else $error("regulator low did not disable bridges");
    supply_bit_a: assert property (supplyLow |=> diag0_r[DG_SUPPLY_LOW] && diag1_r[DG_SUPPLY_LOW])
        else $error("supply low bit not set");
    sticky_a: assert property (diag1_r[DG_HOT] && !diagClear |=> diag1_r[DG_HOT])
        else $error("hot bit lost without clear");
    fault_pin_a: assert property (config_r[1:0] == PIN_FAULT && mon.hotWarn
                                  |=> !statusOutputPin)
        else $error("hot warning did not pull fault output low");
    serial_flag_a: assert property (selLow |=> serialDataOut == $past(commonFlag))
        else $error("serial out does not show common flag");
    thresh_a: assert property (mon.motorUv ##1 mon.motorUv |-> lowThreshSel)
        else $error("regulator threshold not lowered");
endmodule
`default_nettype wire

// ==== verilog/stepper_status_output_pin_pkg.sv ====
// shared constants and carriers of the stepper fault and diagnostic block
`default_nettype none
package stepper_status_output_pin_pkg;
    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] STEP_CHANGE_OFS = 8'h00;
    localparam logic [7:0] CONFIG_OFS      = 8'h04;
    localparam logic [7:0] DIAG0_OFS       = 8'h08;
    localparam logic [7:0] DIAG1_OFS       = 8'h0C;
    localparam logic [7:0] STATUS_OFS      = 8'h10;
    // ------------------------------------------------------------------
    // fields
    // ------------------------------------------------------------------
    localparam int CFG_PIN_SEL_LSB  = 0;
    localparam int CFG_STEP_MODE_LSB = 2;
    localparam logic [3:0] CONFIG_RESET = 4'h0;
    localparam int FLAG_BIT         = 15;
    localparam int DG_SUPPLY_LOW    = 0;
    localparam int DG_HOT           = 1;
    localparam int DG_COLD          = 2;
    localparam int DG_TSD           = 3;
    localparam int DG0_SHORT_LSB    = 4;
    localparam int DG1_STALL        = 4;
    localparam logic [14:0] STATUS_OUTPUT_PIN_RESET = 15'h0000;
    localparam logic [5:0] HOME_INDEX  = 6'h08;
    localparam int STS_INDEX_LSB    = 0;
    localparam int STS_ENABLE_LSB   = 8;
    localparam int STS_DECAY_LSB    = 10;
    localparam int STS_DIR_LSB      = 12;
    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLOCK_NS        = 100;
    localparam int OC_CONFIRM_NS   = 3000;
    localparam logic [7:0] OC_CONFIRM_CYC =
        8'((OC_CONFIRM_NS + CLOCK_NS - 1) / CLOCK_NS);
    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PIN_FAULT = 2'b00,
        PIN_STALL = 2'b01,
        PIN_PWM   = 2'b10,
        PIN_TEMP  = 2'b11
    } pin_sel_e;
    typedef struct packed {
        logic       regUv;
        logic       motorUv;
        logic       hotWarn;
        logic       coldWarn;
        logic       overTemp;
        logic [1:0] lowOc;
        logic       stall;
    } monitor_s;
    typedef struct packed {
        logic       pwmOnA;
        logic [1:0] lowLeg;
    } pwm_s;
    typedef struct packed {
        logic [5:0] level;
        logic       dirPos;
        logic       decayMixed;
        logic       enable;
    } phase_drive_s;
endpackage
`default_nettype wire

// ==== tb/fault_source_model.sv ====
// stand-in for the analog comparators and the pwm state beside the block
`timescale 1ns/100ps
`default_nettype none
module fault_source_model
    import stepper_status_output_pin_pkg::*;
(
    input  wire logic                       clock,    // core clock
    input  wire stepper_status_output_pin_pkg::monitor_s monReq,   // levels the bench asks for
    input  wire stepper_status_output_pin_pkg::pwm_s     pwmReq,   // pwm state the bench asks for
    output stepper_status_output_pin_pkg::monitor_s      monitors, // comparator outputs
    output stepper_status_output_pin_pkg::pwm_s          pwmState  // internal pwm state
);
    // comparators change one clock after the request, never on the edge itself
    always_ff @(posedge clock) begin
        monitors <= monReq;
        pwmState <= pwmReq;
    end
endmodule
`default_nettype wire

// ==== tb/stepper_fault_diagnostics_tb.sv ====
// self-checking bench of the stepper fault and diagnostic block
`timescale 1ns/100ps
`default_nettype none
module stepper_fault_diagnostics_tb;
    import stepper_status_output_pin_pkg::*;
    // ------------------------------------------------------------------
    // signals and rows
    // ------------------------------------------------------------------
    logic         clock, nrst, hsel, hwrite, hready, hreadyout, hresp;
    logic [7:0]   haddr;
    logic [1:0]   htrans;
    logic [2:0]   hsize;
    logic [31:0]  hwdata, hrdata, rd;
    logic         stepPin, dirPin, resetPinN, serialSelectN;
    logic         statusOutputPin, tempRouteSel, serialDataOut, lowThreshSel;
    monitor_s     monReq, monitors;
    pwm_s         pwmReq, pwmState;
    phase_drive_s phaseA, phaseB;
    int           err_count = 0;
    int           checks = 0;
    int           cycles = 0;
    typedef struct packed {logic [5:0] delta; logic [5:0] idx;} step_row_s;
    typedef struct packed {logic [7:0] mon; logic [3:0] bits; logic en; logic lt;} mon_row_s;
    step_row_s stepRows [6] = '{'{6'h10, 6'h18}, '{6'h30, 6'h08}, '{6'h37, 6'h3F},
                                '{6'h01, 6'h00}, '{6'h10, 6'h10}, '{6'h3F, 6'h0F}};
    mon_row_s  monRows [5] = '{'{8'h80, 4'h1, 1'b0, 1'b0}, '{8'h40, 4'h1, 1'b1, 1'b1},
                               '{8'h20, 4'h2, 1'b1, 1'b0}, '{8'h10, 4'h4, 1'b1, 1'b0},
                               '{8'h08, 4'h8, 1'b0, 1'b0}};
    assign hready = hreadyout;

    stepper_fault_diagnostics i_dut (.clock(clock), .nrst(nrst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .stepPin(stepPin),
        .dirPin(dirPin), .resetPinN(resetPinN), .serialSelectN(serialSelectN),
        .monitors(monitors), .pwmState(pwmState), .statusOutputPin(statusOutputPin),
        .tempRouteSel(tempRouteSel), .serialDataOut(serialDataOut),
        .lowThreshSel(lowThreshSel), .phaseA(phaseA), .phaseB(phaseB));
    fault_source_model i_src (.clock(clock), .monReq(monReq), .pwmReq(pwmReq),
        .monitors(monitors), .pwmState(pwmState));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkBit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: bit %b expected %b", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clock);
    endtask
    // one single-word transfer; read data lands in rd
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        do @(posedge clock); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clock); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic end_of_test();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            end_of_test();
        end
    end
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        nrst = 1'b0;
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        stepPin = 1'b0;
        dirPin = 1'b1;
        resetPinN = 1'b1;
        serialSelectN = 1'b1;
        monReq = '0;
        pwmReq = '0;
        wt(16);
        nrst <= 1'b1;
        wt(3);
        chkBit(statusOutputPin, 1'b1);
        chkBit(hreadyout, 1'b1);
        chkBit(hresp, 1'b0);
        bus(1'b0, STATUS_OFS, 32'h0);
        chkWord(rd & 32'h3FF, 32'h308);
        bus(1'b0, CONFIG_OFS, 32'h0);
        chkWord(rd, 32'h0);
        foreach (stepRows[i]) begin
            bus(1'b1, STEP_CHANGE_OFS, {26'h0, stepRows[i].delta});
            bus(1'b0, STATUS_OFS, 32'h0);
            chkWord(rd & 32'h3F, {26'h0, stepRows[i].idx});
        end
        foreach (monRows[i]) begin
            bus(1'b1, DIAG0_OFS, 32'h0);
            monReq <= monitor_s'(monRows[i].mon);
            wt(8);
            chkBit(statusOutputPin, 1'b0);
            chkBit(phaseA.enable & phaseB.enable, monRows[i].en);
            chkBit(lowThreshSel, monRows[i].lt);
            monReq <= '0;
            wt(8);
            chkBit(statusOutputPin, 1'b1);
            chkBit(phaseA.enable & phaseB.enable, 1'b1);
            bus(1'b0, DIAG0_OFS, 32'h0);
            chkWord(rd, 32'h8000 | 32'(monRows[i].bits));
            bus(1'b0, DIAG1_OFS, 32'h0);
            chkWord(rd, 32'h8000 | 32'(monRows[i].bits));
        end
        serialSelectN <= 1'b0;
        wt(6);
        chkBit(serialDataOut, 1'b1);
        bus(1'b1, DIAG1_OFS, 32'h0);
        wt(2);
        chkBit(serialDataOut, 1'b0);
        serialSelectN <= 1'b1;
        // overcurrent that drops before the delay must leave no trace
        // two short bursts add up past the delay unless the timer restarts
        repeat (2) begin
            monReq.lowOc <= 2'b01;
            wt(20);
            monReq.lowOc <= 2'b00;
            wt(8);
        end
        bus(1'b0, DIAG0_OFS, 32'h0);
        chkWord(rd, 32'h0);
        pwmReq.lowLeg <= 2'b01;
        monReq.lowOc <= 2'b01;
        wt(40);
        monReq.lowOc <= 2'b00;
        wt(8);
        chkBit(phaseA.enable, 1'b0);
        chkBit(phaseB.enable, 1'b1);
        chkBit(statusOutputPin, 1'b0);
        bus(1'b0, DIAG0_OFS, 32'h0);
        chkWord(rd, 32'h8020);
        stepPin <= 1'b1;
        wt(8);
        chkBit(phaseA.enable, 1'b1);
        bus(1'b0, DIAG0_OFS, 32'h0);
        chkWord(rd, 32'h8020);
        bus(1'b0, STATUS_OFS, 32'h0);
        chkWord(rd & 32'h1FFF, 32'h171F);
        chkWord(32'(phaseA.level), 32'h03);
        chkWord(32'(phaseB.level), 32'h3C);
        chkBit(phaseB.dirPos, 1'b0);
        stepPin <= 1'b0;
        resetPinN <= 1'b0;
        wt(8);
        resetPinN <= 1'b1;
        bus(1'b0, DIAG0_OFS, 32'h0);
        chkWord(rd, 32'h0);
        bus(1'b1, CONFIG_OFS, 32'h1);
        monReq.stall <= 1'b1;
        wt(8);
        chkBit(statusOutputPin, 1'b0);
        monReq.stall <= 1'b0;
        bus(1'b0, DIAG1_OFS, 32'h0);
        chkWord(rd, 32'h8010);
        bus(1'b1, CONFIG_OFS, 32'h2);
        pwmReq.pwmOnA <= 1'b1;
        wt(4);
        chkBit(statusOutputPin, 1'b1);
        pwmReq.pwmOnA <= 1'b0;
        wt(4);
        chkBit(statusOutputPin, 1'b0);
        bus(1'b1, CONFIG_OFS, 32'h3);
        wt(2);
        chkBit(tempRouteSel, 1'b1);
        // half, quarter and sixteenth step backwards from 0x1F
        dirPin <= 1'b0;
        for (int m = 1; m < 4; m++) begin
            bus(1'b1, CONFIG_OFS, 32'(m) << 2);
            stepPin <= 1'b1;
            wt(8);
            stepPin <= 1'b0;
            wt(4);
        end
        dirPin <= 1'b1;
        bus(1'b0, STATUS_OFS, 32'h0);
        chkWord(rd & 32'h103F, 32'h12);
        bus(1'b1, 8'h20, 32'hFFFF_FFFF);
        bus(1'b0, 8'h20, 32'h0);
        chkWord(rd, 32'h0);
        nrst <= 1'b0;
        wt(2);
        nrst <= 1'b1;
        wt(3);
        bus(1'b0, STATUS_OFS, 32'h0);
        chkWord(rd & 32'h3F, 32'h08);
        bus(1'b0, CONFIG_OFS, 32'h0);
        chkWord(rd, 32'h0);
        end_of_test();
    end
endmodule
`default_nettype wire
